// ===== core/rfc_rx_ctrl.sv
// rfc_rx_ctrl: receive fifo mode control. sync search, payload selection,
// crc check, fifo fill and drain, rx state exit, axi4-lite registers.
// assumes modem strobes are synchronous to clk_sys.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module rfc_rx_ctrl (
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire rfc_pkg::rfc_axi_req_t axi_req,
	output rfc_pkg::rfc_axi_rsp_t      axi_rsp,
	input  wire rfc_pkg::rfc_modem_t   modem,
	output logic                       irq,
	output logic                       raw_receive_bitstream,
	output rfc_pkg::rfc_op_t           op_state
);
	import rfc_pkg::*;

	typedef struct packed {
		logic              aw_held;
		logic [ADDR_W-1:0] awaddr;
		logic              w_held;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rd_pend;
		logic [ADDR_W-1:0] rd_addr;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              rxon;
		logic              ready_en;
		logic              mpk;
		logic              raw_en;
		logic              pk_en;
		logic              crc_en;
		logic [2:0]        hdr_len;
		logic [1:0]        sync_len;
		logic [7:0]        pay_len;
		logic [31:0]       sync;
		logic [5:0]        afthr;
		logic [NEV-1:0]    status;
		logic [NEV-1:0]    mask;
		rfc_op_t           op;
		rfc_rx_t           rx;
		logic              pre_q;
		logic [31:0]       shift;
		logic [2:0]        bit_cnt;
		logic [8:0]        byte_idx;
		logic [15:0]       crc;
		logic [PTR_W-1:0]  wptr;
		logic [PTR_W-1:0]  rptr;
		logic [PTR_W:0]    count;
		logic              irq;
		logic              raw_bit;
	} rfc_st_t;

	rfc_st_t s_r;
	rfc_st_t s_nxt;

	logic             mem_we;
	logic [7:0]       mem_wd;
	logic [7:0]       mem_q;
	logic [NEV-1:0]   ev;
	logic [NEV-1:0]   w1c;
	logic             push;
	logic             pop;
	logic             fclr;
	logic [7:0]       rx_byte;
	logic [31:0]      wv;
	logic [8:0]       pay_end;
	logic [8:0]       pkt_end;

	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// msb-first ccitt; running it over the trailing crc leaves zero
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[15] ^ d[i]) begin
				r = {r[14:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	// compares the newest 1..4 bytes against the top of the sync word
	function automatic logic sync_hit(input logic [31:0] sh,
		input logic [31:0] sw, input logic [1:0] len);
		logic [31:0] m;
		m = 32'hFFFFFFFF >> (5'(3 - len) * 8);
		return ((sh & m) == (sw >> (5'(3 - len) * 8)));
	endfunction

	always_comb begin
		s_nxt   = s_r;
		mem_we  = 1'b0;
		mem_wd  = 8'h00;
		ev      = '0;
		w1c     = '0;
		push    = 1'b0;
		pop     = 1'b0;
		fclr    = 1'b0;
		wv      = 32'h00000000;
		rx_byte = {s_r.shift[6:0], modem.bit_val};
		pay_end = 9'({6'h00, s_r.hdr_len}) + 9'({1'b0, s_r.pay_len});
		pkt_end = pay_end + (s_r.crc_en ? 9'h002 : 9'h000);

		// write channel: address and data taken in either order
		if (axi_req.awvalid && s_r.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.awaddr  = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_r.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.wdata  = axi_req.wdata;
			s_nxt.wstrb  = axi_req.wstrb;
		end
		if (s_r.bvalid && axi_req.bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = R_OKAY;
			case (s_r.awaddr)
			A_CTRL1: begin
				wv = wmerge({29'h0, s_r.rxon, 1'b0, s_r.ready_en},
					s_r.wdata, s_r.wstrb);
				s_nxt.rxon     = wv[B_RXON];
				s_nxt.ready_en = wv[B_READY];
			end
			A_CTRL2: begin
				wv = wmerge({27'h0, s_r.mpk, 4'h0}, s_r.wdata, s_r.wstrb);
				s_nxt.mpk = wv[B_MPK];
				fclr      = wv[B_FFCLR];
			end
			A_PKT: begin
				wv = wmerge({8'h0, s_r.pay_len, 6'h0, s_r.sync_len, 1'b0,
					s_r.hdr_len, 2'h0, s_r.crc_en, s_r.pk_en},
					s_r.wdata, s_r.wstrb);
				s_nxt.pk_en    = wv[B_PKEN];
				s_nxt.crc_en   = wv[B_CRCEN];
				s_nxt.hdr_len  = wv[B_HDR +: 3];
				s_nxt.sync_len = wv[B_SLEN +: 2];
				s_nxt.pay_len  = wv[B_PAY +: 8];
			end
			A_SYNC: begin
				s_nxt.sync = wmerge(s_r.sync, s_r.wdata, s_r.wstrb);
			end
			A_FCTRL: begin
				wv = wmerge({26'h0, s_r.afthr}, s_r.wdata, s_r.wstrb);
				s_nxt.afthr = wv[5:0];
			end
			A_STATUS: begin
				wv  = wmerge(32'h0, s_r.wdata, s_r.wstrb);
				w1c = wv[NEV-1:0];
			end
			A_MASK: begin
				wv = wmerge({27'h0, s_r.mask}, s_r.wdata, s_r.wstrb);
				s_nxt.mask = wv[NEV-1:0];
			end
			A_GPIO: begin
				wv = wmerge({31'h0, s_r.raw_en}, s_r.wdata, s_r.wstrb);
				s_nxt.raw_en = wv[0];
			end
			A_FIFO, A_INFO: begin
				s_nxt.bresp = R_OKAY;
			end
			default: begin
				s_nxt.bresp = R_SLVERR;
			end
			endcase
		end

		// read channel: memory data is one cycle behind the address
		if (s_r.rvalid && axi_req.rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (axi_req.arvalid && s_r.arready) begin
			s_nxt.rd_pend = 1'b1;
			s_nxt.rd_addr = axi_req.araddr;
			if (axi_req.araddr == A_FIFO && s_r.count != '0) begin
				pop = 1'b1;
			end
		end
		if (s_r.rd_pend) begin
			s_nxt.rd_pend = 1'b0;
			s_nxt.rvalid  = 1'b1;
			s_nxt.rresp   = R_OKAY;
			case (s_r.rd_addr)
			A_CTRL1:  s_nxt.rdata = {29'h0, s_r.rxon, 1'b0, s_r.ready_en};
			A_CTRL2:  s_nxt.rdata = {27'h0, s_r.mpk, 4'h0};
			A_PKT:    s_nxt.rdata = {8'h0, s_r.pay_len, 6'h0, s_r.sync_len,
				1'b0, s_r.hdr_len, 2'h0, s_r.crc_en, s_r.pk_en};
			A_SYNC:   s_nxt.rdata = s_r.sync;
			A_FCTRL:  s_nxt.rdata = {26'h0, s_r.afthr};
			A_FIFO:   s_nxt.rdata = {24'h0, mem_q};
			A_STATUS: s_nxt.rdata = {27'h0, s_r.status};
			A_MASK:   s_nxt.rdata = {27'h0, s_r.mask};
			// rssi passes through in half-decibel steps
			A_INFO:   s_nxt.rdata = {14'h0, s_r.op, 1'b0, s_r.count,
				modem.rssi};
			A_GPIO:   s_nxt.rdata = {31'h0, s_r.raw_en};
			default: begin
				s_nxt.rdata = 32'h00000000;
				s_nxt.rresp = R_SLVERR;
			end
			endcase
		end

		// receive path
		s_nxt.pre_q = modem.pre_valid;
		if (!s_r.rxon) begin
			s_nxt.rx = RX_OFF;
		end else begin
			case (s_r.rx)
			RX_OFF: begin
				s_nxt.rx    = RX_SEARCH;
				s_nxt.shift = 32'h00000000;
			end
			RX_SEARCH: begin
				if (modem.pre_valid && !s_r.pre_q) begin
					ev[S_PREA] = 1'b1;
				end
				if (modem.bit_en) begin
					s_nxt.shift = {s_r.shift[30:0], modem.bit_val};
					if (modem.pre_valid && sync_hit(s_nxt.shift, s_r.sync,
						s_r.sync_len)) begin
						s_nxt.rx       = RX_DATA;
						s_nxt.bit_cnt  = 3'h0;
						s_nxt.byte_idx = 9'h000;
						s_nxt.crc      = CRC_INIT;
						ev[S_SYNC]     = 1'b1;
					end
				end
			end
			RX_DATA: begin
				if (modem.bit_en) begin
					s_nxt.shift   = {s_r.shift[30:0], modem.bit_val};
					s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
					if (s_r.bit_cnt == 3'h7) begin
						s_nxt.byte_idx = s_r.byte_idx + 9'h001;
						mem_wd = rx_byte;
						if (!s_r.pk_en) begin
							push = 1'b1;
						end else begin
							push = (s_r.byte_idx >= 9'({6'h00, s_r.hdr_len}))
								&& (s_r.byte_idx < pay_end);
							s_nxt.crc = crc_byte(s_r.crc, rx_byte);
							if (s_nxt.byte_idx == pkt_end) begin
								s_nxt.rx = RX_SEARCH;
								s_nxt.shift = 32'h00000000;
								if (s_r.crc_en && s_nxt.crc != 16'h0000) begin
									ev[S_CRCER] = 1'b1;
								end else begin
									ev[S_PKVAL] = 1'b1;
									if (!s_r.mpk) begin
										s_nxt.rxon = 1'b0;
										s_nxt.rx   = RX_OFF;
									end
								end
							end
						end
					end
				end
			end
			default: begin
				s_nxt.rx = RX_OFF;
			end
			endcase
		end

		// fifo pointers; clear beats both push and pop
		if (fclr) begin
			s_nxt.wptr  = '0;
			s_nxt.rptr  = '0;
			s_nxt.count = '0;
		end else begin
			// a full fifo refuses the byte rather than overwrite
			if (push && s_r.count != (PTR_W+1)'(DEPTH)) begin
				mem_we     = 1'b1;
				s_nxt.wptr = s_r.wptr + 1'b1;
			end
			if (pop) begin
				s_nxt.rptr = s_r.rptr + 1'b1;
			end
			s_nxt.count = s_r.count + (PTR_W+1)'(mem_we)
				- (PTR_W+1)'(pop);
		end
		if (s_r.count < {1'b0, s_r.afthr}
			&& s_nxt.count >= {1'b0, s_r.afthr}) begin
			ev[S_AFULL] = 1'b1;
		end

		// a fresh event outlives a clear in the same cycle
		s_nxt.status  = (s_r.status & ~w1c) | ev;
		s_nxt.irq     = |(s_nxt.status & s_nxt.mask);
		s_nxt.op      = s_nxt.rxon ? OP_RX :
			(s_nxt.ready_en ? OP_READY : OP_IDLE);
		s_nxt.raw_bit = s_r.raw_en && (modem.bit_en ? modem.bit_val
			: s_r.raw_bit);
		s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rd_pend && !s_nxt.rvalid;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_r          <= '0;
			s_r.awready  <= 1'b1;
			s_r.wready   <= 1'b1;
			s_r.arready  <= 1'b1;
			s_r.crc_en   <= CRCEN_RST;
			s_r.hdr_len  <= HDR_RST;
			s_r.sync_len <= SLEN_RST;
			s_r.pay_len  <= PAY_RST;
			s_r.sync     <= SYNC_RST;
			s_r.afthr    <= AFTHR_RST;
			s_r.op       <= OP_IDLE;
			s_r.rx       <= RX_OFF;
			s_r.crc      <= CRC_INIT;
		end else begin
			s_r <= s_nxt;
		end
	end

	rfc_mem #(.DEPTH(DEPTH), .AW(PTR_W)) u_mem (
		.clk_sys (clk_sys),
		.we      (mem_we),
		.waddr   (s_r.wptr),
		.wdata   (mem_wd),
		.raddr   (s_r.rptr),
		.rdata   (mem_q)
	);

	assign axi_rsp = '{awready: s_r.awready, wready: s_r.wready,
		bvalid: s_r.bvalid, bresp: s_r.bresp, arready: s_r.arready,
		rvalid: s_r.rvalid, rdata: s_r.rdata, rresp: s_r.rresp};
	assign irq                   = s_r.irq;
	assign raw_receive_bitstream = s_r.raw_bit;
	assign op_state              = s_r.op;
endmodule
`default_nettype wire

// ===== include/rfc_pkg.sv
// rfc_pkg: register map, reset values, field positions and carriers for
// the receive fifo control block.
// assumes a 32-bit axi4-lite master and a modem on the same clock.
package rfc_pkg;

	localparam int ADDR_W = 8;
	localparam int DEPTH  = 64;
	localparam int PTR_W  = 6;

	// byte addresses
	localparam logic [7:0] A_CTRL1  = 8'h00;
	localparam logic [7:0] A_CTRL2  = 8'h04;
	localparam logic [7:0] A_PKT    = 8'h08;
	localparam logic [7:0] A_SYNC   = 8'h0C;
	localparam logic [7:0] A_FCTRL  = 8'h10;
	localparam logic [7:0] A_FIFO   = 8'h14;
	localparam logic [7:0] A_STATUS = 8'h18;
	localparam logic [7:0] A_MASK   = 8'h1C;
	localparam logic [7:0] A_INFO   = 8'h20;
	localparam logic [7:0] A_GPIO   = 8'h24;

	// field positions
	localparam int B_READY  = 0;
	localparam int B_RXON   = 2;
	localparam int B_FFCLR  = 1;
	localparam int B_MPK    = 4;
	localparam int B_PKEN   = 0;
	localparam int B_CRCEN  = 1;
	localparam int B_HDR    = 4;
	localparam int B_SLEN   = 8;
	localparam int B_PAY    = 16;
	localparam int B_CNT    = 8;
	localparam int B_OPST   = 16;

	// status / mask bits
	localparam int S_AFULL = 0;
	localparam int S_PKVAL = 1;
	localparam int S_CRCER = 2;
	localparam int S_SYNC  = 3;
	localparam int S_PREA  = 4;
	localparam int NEV     = 5;

	// reset values, crc constants and response codes
	localparam logic [5:0]  AFTHR_RST = 6'h37;
	localparam logic [31:0] SYNC_RST  = 32'h2DD40000;
	localparam logic [1:0]  SLEN_RST  = 2'h1;
	localparam logic [2:0]  HDR_RST   = 3'h2;
	localparam logic [7:0]  PAY_RST   = 8'h08;
	localparam logic        CRCEN_RST = 1'b1;
	localparam logic [15:0] CRC_INIT  = 16'hFFFF;
	localparam logic [15:0] CRC_POLY  = 16'h1021;
	localparam logic [1:0]  R_OKAY    = 2'h0;
	localparam logic [1:0]  R_SLVERR  = 2'h2;

	typedef enum logic [1:0] {OP_IDLE, OP_READY, OP_RX} rfc_op_t;
	typedef enum logic [1:0] {RX_OFF, RX_SEARCH, RX_DATA} rfc_rx_t;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} rfc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} rfc_axi_rsp_t;

	typedef struct packed {
		logic       bit_en;
		logic       bit_val;
		logic       pre_valid;
		logic [7:0] rssi;
	} rfc_modem_t;

endpackage

// ===== core/rfc_mem.sv
// rfc_mem: byte memory behind the receive fifo, one write port and one
// read port, read data registered.
// assumes addresses stable in the cycle before the data is used.
`timescale 1ns/10ps
`default_nettype none
module rfc_mem #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic          clk_sys,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic [AW-1:0] raddr,
	output logic [7:0]         rdata
);
	logic [7:0] mem [DEPTH];

	// no reset on the array: contents are meaningless until written
	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// ===== verification/rfc_rx_ctrl_props.sv
// rfc_rx_ctrl_props: bus timing and raw pin checks on the top ports.
// assumes the bus answers two edges after a request is taken.
`timescale 1ns/10ps
`default_nettype none
module rfc_rx_ctrl_props (
	input wire logic                  clk_sys,
	input wire logic                  rstn,
	input wire rfc_pkg::rfc_axi_req_t axi_req,
	input wire rfc_pkg::rfc_axi_rsp_t axi_rsp,
	input wire rfc_pkg::rfc_modem_t   modem,
	input wire logic                  irq,
	input wire logic                  raw_receive_bitstream,
	input wire rfc_pkg::rfc_op_t      op_state
);
	import rfc_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	wire logic wr_t = axi_req.awvalid && axi_rsp.awready &&
		axi_req.wvalid && axi_rsp.wready;
	wire logic rd_t = axi_req.arvalid && axi_rsp.arready;
	property p_wr_lat;
		wr_t |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_rd_lat;
		rd_t |=> !axi_rsp.rvalid ##1 axi_rsp.rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_rd_err;
		rd_t && axi_req.araddr > A_GPIO |-> ##2
			axi_rsp.rresp == R_SLVERR && axi_rsp.rdata == 32'h0;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("unmapped read");
	property p_r_hold;
		axi_rsp.rvalid && !axi_req.rready |=>
			axi_rsp.rvalid && $stable(axi_rsp.rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data moved");
	property p_b_hold;
		axi_rsp.bvalid && !axi_req.bready |=>
			axi_rsp.bvalid && $stable(axi_rsp.bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write resp moved");
	property p_b_busy;
		axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
	endproperty
	a_b_busy: assert property (p_b_busy) else $error("ready while busy");
	property p_b_back;
		axi_rsp.bvalid && axi_req.bready |=>
			axi_rsp.awready && axi_rsp.wready;
	endproperty
	a_b_back: assert property (p_b_back) else $error("ready not back");
	property p_raw;
		$rose(raw_receive_bitstream) |->
			$past(modem.bit_en) && $past(modem.bit_val);
	endproperty
	a_raw: assert property (p_raw) else $error("raw pin without bit");
	c_exit: cover property (op_state == OP_RX ##1 op_state == OP_READY);
	c_irq: cover property ($rose(irq));
	c_raw: cover property ($rose(raw_receive_bitstream));
endmodule
bind rfc_rx_ctrl rfc_rx_ctrl_props i_rfc_rx_ctrl_props (
	.clk_sys(clk_sys), .rstn(rstn), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .modem(modem), .irq(irq),
	.raw_receive_bitstream(raw_receive_bitstream), .op_state(op_state));
`default_nettype wire

// ===== verification/rfc_modem_model.sv
// rfc_modem_model: demodulator side, bits and preamble flag.
// assumes the caller starts each task right after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module rfc_modem_model (
	input wire logic           clk_sys,
	output rfc_pkg::rfc_modem_t modem
);
	import rfc_pkg::*;
	initial modem = '{1'b0, 1'b0, 1'b0, 8'h5A};
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_sys);
			modem.bit_en  <= 1'b1;
			modem.bit_val <= b[i];
		end
		@(posedge clk_sys);
		modem.bit_en  <= 1'b0;
		// line not held after the bit
		modem.bit_val <= ~b[0];
	endtask
	task automatic level(input logic [7:0] v);
		@(posedge clk_sys);
		modem.rssi <= v;
	endtask
	task automatic pre(input logic v);
		@(posedge clk_sys);
		modem.pre_valid <= v;
	endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// testbench: registers, packets, fifo fill and drain for rfc_rx_ctrl.
// assumes the modem model drives bits on the same clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import rfc_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} rfc_row_t;
	logic         clk_sys;
	logic         rstn;
	rfc_axi_req_t axi_req;
	rfc_axi_rsp_t axi_rsp;
	rfc_modem_t   modem;
	logic         irq;
	logic         raw;
	rfc_op_t      op_state;
	int           fail_count = 0;
	int           tests_run = 0;
	int           cyc = 0;
	logic [31:0]  d;
	logic [1:0]   r;
	rfc_row_t rows[10] = '{'{A_CTRL1, 32'h0, R_OKAY},
		'{A_CTRL2, 32'h0, R_OKAY}, '{A_PKT, 32'h00080122, R_OKAY},
		'{A_SYNC, 32'h2DD40000, R_OKAY}, '{A_FCTRL, 32'h37, R_OKAY},
		'{A_STATUS, 32'h0, R_OKAY}, '{A_MASK, 32'h0, R_OKAY},
		'{A_INFO, 32'h5A, R_OKAY}, '{A_GPIO, 32'h0, R_OKAY},
		'{8'h28, 32'h0, R_SLVERR}};
	rfc_rx_ctrl i_rfc_rx_ctrl (.clk_sys(clk_sys), .rstn(rstn),
		.axi_req(axi_req), .axi_rsp(axi_rsp), .modem(modem), .irq(irq),
		.raw_receive_bitstream(raw), .op_state(op_state));
	rfc_modem_model i_rfc_modem_model (.clk_sys(clk_sys), .modem(modem));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		// well above the roughly 1300 cycles the run needs
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic wrs(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s);
		logic [1:0] t;
		t = 2'b00;
		axi_req.awaddr  <= a;
		axi_req.wdata   <= v;
		axi_req.wstrb   <= s;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid  <= 1'b1;
		while (t != 2'b11) begin
			@(posedge clk_sys);
			t |= {axi_rsp.wready === 1'b1, axi_rsp.awready === 1'b1};
			axi_req.awvalid <= ~t[0];
			axi_req.wvalid  <= ~t[1];
		end
		do @(posedge clk_sys); while (axi_rsp.bvalid !== 1'b1);
		axi_req.bready <= 1'b1;
		@(posedge clk_sys);
		axi_req.bready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		wrs(a, v, 4'hF);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rr);
		axi_req.araddr  <= a;
		axi_req.arvalid <= 1'b1;
		do @(posedge clk_sys); while (axi_rsp.arready !== 1'b1);
		axi_req.arvalid <= 1'b0;
		do @(posedge clk_sys); while (axi_rsp.rvalid !== 1'b1);
		axi_req.rready <= 1'b1;
		@(posedge clk_sys);
		v  = axi_rsp.rdata;
		rr = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
	endtask
	function automatic logic [15:0] crc8(logic [15:0] c, logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0);
		return c;
	endfunction
	// sync, two header bytes, eight payload bytes, crc
	task automatic pkt(input logic [7:0] p, input logic bad);
		logic [15:0] c;
		logic [7:0]  b;
		c = CRC_INIT;
		i_rfc_modem_model.send(8'h2D);
		i_rfc_modem_model.send(8'hD4);
		for (int i = 0; i < 10; i++) begin
			b = (i < 2) ? 8'(i + 1) : p + 8'(i - 2);
			c = crc8(c, b);
			i_rfc_modem_model.send(b);
		end
		i_rfc_modem_model.send(c[15:8] ^ {7'h0, bad});
		i_rfc_modem_model.send(c[7:0]);
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic count_is(input logic [6:0] n);
		rd(A_INFO, d, r);
		chk("count", {25'h0, d[14:8]}, {25'h0, n});
	endtask
	initial begin
		axi_req = '0;
		rstn = 1'b0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		foreach (rows[i]) begin
			rd(rows[i].a, d, r);
			chk("reg", d, rows[i].d);
			chk("resp", {30'h0, r}, {30'h0, rows[i].r});
		end
		$display("reset values done");
		// only byte 1 may change; the compared top bytes stay intact
		wrs(A_SYNC, 32'h11223344, 4'h2);
		rd(A_SYNC, d, r);
		chk("strobe", d, 32'h2DD43300);
		$display("strobe write done");
		wr(A_PKT, 32'h00080123);
		wr(A_FCTRL, 32'h4);
		wr(A_MASK, 32'h2);
		i_rfc_modem_model.pre(1'b1);
		wr(A_CTRL1, 32'h5);
		pkt(8'h10, 1'b0);
		chk("op", 32'(op_state), 32'(OP_READY));
		chk("irq", 32'(irq), 32'h1);
		rd(A_STATUS, d, r);
		chk("status", d & 32'h7, 32'h3);
		count_is(7'd8);
		for (int i = 0; i < 8; i++) begin
			rd(A_FIFO, d, r);
			chk("fifo", {24'h0, d[7:0]}, 32'h10 + i);
		end
		rd(A_FIFO, d, r);
		count_is(7'd0);
		wr(A_STATUS, 32'h1F);
		repeat (2) @(posedge clk_sys);
		chk("irq clear", 32'(irq), 32'h0);
		$display("single packet done");
		wr(A_CTRL2, 32'h10);
		wr(A_CTRL1, 32'h5);
		pkt(8'h20, 1'b0);
		chk("op multi", 32'(op_state), 32'(OP_RX));
		pkt(8'h30, 1'b1);
		rd(A_STATUS, d, r);
		chk("crc err", d & 32'h4, 32'h4);
		count_is(7'd16);
		// a pointer moved by the empty read would skip this byte
		rd(A_FIFO, d, r);
		chk("after empty", {24'h0, d[7:0]}, 32'h20);
		wr(A_CTRL2, 32'h12);
		count_is(7'd0);
		$display("multi packet done");
		wr(A_PKT, 32'h00080122);
		wr(A_STATUS, 32'h1F);
		i_rfc_modem_model.pre(1'b0);
		i_rfc_modem_model.send(8'h2D);
		i_rfc_modem_model.send(8'hD4);
		i_rfc_modem_model.send(8'hAA);
		rd(A_STATUS, d, r);
		chk("no sync", d & 32'h8, 32'h0);
		count_is(7'd0);
		i_rfc_modem_model.pre(1'b1);
		wr(A_GPIO, 32'h1);
		i_rfc_modem_model.send(8'h2D);
		i_rfc_modem_model.send(8'hD4);
		for (int i = 0; i < 70; i++)
			i_rfc_modem_model.send(8'(i));
		// pin settles after the edge that took the last bit
		@(posedge clk_sys);
		chk("raw", 32'(raw), 32'h1);
		count_is(7'd64);
		rd(A_FIFO, d, r);
		chk("oldest", {24'h0, d[7:0]}, 32'h0);
		$display("raw fill done");
		i_rfc_modem_model.level(8'hA7);
		rd(A_INFO, d, r);
		chk("rssi", {24'h0, d[7:0]}, 32'hA7);
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		count_is(7'd0);
		rd(A_CTRL1, d, r);
		chk("ctrl1 reset", d, 32'h0);
		$display("mid reset done");
		final_report();
	end
endmodule
`default_nettype wire
